// ### kps_pin_regs.sv
/*
 * PS/2 port pin signal registers: output signal control register that
 * drives four data and four clock lines as open-drain pins and selects
 * the channels served by the shift engine, plus an input signal register
 * that returns the synchronised level of all eight lines.
 * Assumes: the shift engine, its control and status registers sit
 * outside and run on clk_sys; the pad ring resolves the open-drain wire
 * from the enables; pins are sampled on clk_link before crossing.
 */
// Strobed register access is this design's own decision.
module kps_pin_regs
    import kps_pkg::*;
(
    input  wire logic             clk_sys,
    input  wire logic             nrst,
    input  wire logic             clk_link,
    input  wire logic [15:0]      reg_addr,
    input  wire logic [7:0]       reg_wdata,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    output logic      [7:0]       reg_rdata,
    input  wire logic             shift_enable,
    input  wire logic             weak_pullup_enable,
    input  wire logic [3:0]       tx_active_entry,
    input  wire logic [3:0]       engine_data_low,
    input  wire logic [3:0]       engine_clock_low,
    output logic      [3:0]       channel_active,
    output logic                  shift_reset,
    input  wire logic [3:0]       port_data_line_in,
    input  wire logic [3:0]       port_clock_line_in,
    output kps_pin_drv_t          port_data_line,
    output kps_pin_drv_t          port_clock_line
);

    // ------------------------------------------------------------------
    // Layout helpers
    // ------------------------------------------------------------------

    // Packs per-channel data and clock bits into the register byte order
    function automatic kps_sig_t kps_pack(
        input logic [3:0] dat,
        input logic [3:0] clk
    );
        kps_sig_t s;
        s.dat1 = dat[0];
        s.dat2 = dat[1];
        s.dat3 = dat[2];
        s.clock_release_ch1 = clk[0];
        s.clock_release_ch2 = clk[1];
        s.clock_release_ch3 = clk[2];
        s.dat4 = dat[3];
        s.clock_release_ch4 = clk[3];
        return s;
    endfunction

    // Extracts the four data bits in channel order
    function automatic logic [3:0] kps_dat(input kps_sig_t s);
        return {s.dat4, s.dat3, s.dat2, s.dat1};
    endfunction

    // Extracts the four clock bits in channel order
    function automatic logic [3:0] kps_clk(input kps_sig_t s);
        return {s.clock_release_ch4, s.clock_release_ch3, s.clock_release_ch2, s.clock_release_ch1};
    endfunction

    // ------------------------------------------------------------------
    // Register bus decode
    // ------------------------------------------------------------------
    kps_sig_t   out_sig_q;
    kps_sig_t   out_sig_d;
    kps_sig_t   in_level;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    wire  logic hit_out;
    wire  logic hit_in;
    wire  logic wr_out;
    wire  logic [3:0] wdat_bits;
    wire  logic [3:0] clk_bits;
    wire  kps_sig_t   hw_set;

    // Address matches for the two registers
    assign hit_out = (reg_addr == KPS_OFS_OUTPUT_SIGNAL);
    assign hit_in  = (reg_addr == KPS_OFS_INPUT_SIGNAL);
    assign wr_out  = reg_wr & hit_out;

    // Field views of the output register
    assign wdat_bits = kps_dat(out_sig_q);
    assign clk_bits  = kps_clk(out_sig_q);

    // ------------------------------------------------------------------
    // Output signal register
    // ------------------------------------------------------------------

    // Transmit-active entry re-releases the data line of that channel
    assign hw_set = kps_pack(tx_active_entry & {4{shift_enable}}, 4'h0);

    // Hardware set is ORed last so it wins over a same-cycle clear
    assign out_sig_d = (wr_out ? kps_sig_t'(reg_wdata) : out_sig_q)
                     | hw_set;

    // Register storage, 0x47 out of reset
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            out_sig_q <= kps_sig_t'(KPS_RST_OUTPUT_SIGNAL);
        end else begin
            out_sig_q <= out_sig_d;
        end
    end

    // ------------------------------------------------------------------
    // Channel selection and shift engine reset
    // ------------------------------------------------------------------

    // Clock bits at 1 pick the channels the engine serves
    assign channel_active = shift_enable ? clk_bits : 4'h0;

    // All clock bits low is a reset of status and state machine
    assign shift_reset = (clk_bits == 4'h0);

    // ------------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------------
    logic [3:0] dat_low_q;
    logic [3:0] clk_low_q;
    wire  logic [3:0] dat_low_d;
    wire  logic [3:0] clk_low_d;

    // Per-channel open-drain decisions
    genvar ch;
    generate
        for (ch = 0; ch < KPS_CHANNELS; ch++) begin : g_drive
            // Data: write-data 0 pulls low; engine may pull too if enabled
            assign dat_low_d[ch] = ~wdat_bits[ch]
                | (shift_enable & clk_bits[ch] & engine_data_low[ch]);
            // Clock: bit 0 always pulls low; bit 1 releases or serves engine
            assign clk_low_d[ch] = ~clk_bits[ch]
                | (shift_enable & clk_bits[ch] & engine_clock_low[ch]);
        end
    endgenerate

    // Pin enables come from flip-flops so the pads see clean levels
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            dat_low_q <= KPS_RST_DRIVE;
            clk_low_q <= KPS_RST_DRIVE;
        end else begin
            dat_low_q <= dat_low_d;
            clk_low_q <= clk_low_d;
        end
    end

    // Open-drain outputs; pull-up only where the line is not driven low
    assign port_data_line.o   = 4'h0;
    assign port_data_line.oe  = dat_low_q;
    assign port_data_line.pu  = {4{weak_pullup_enable}}
                              & ~dat_low_q;
    assign port_clock_line.o  = 4'h0;
    assign port_clock_line.oe = clk_low_q;
    assign port_clock_line.pu = {4{weak_pullup_enable}}
                              & ~clk_low_q;

    // ------------------------------------------------------------------
    // Pin sampling on the link clock
    // ------------------------------------------------------------------
    logic [7:0] lnk_s1_q;
    logic [7:0] lnk_s2_q;
    wire  kps_sig_t pin_raw;

    // Raw pin levels arranged in register order
    assign pin_raw = kps_pack(port_data_line_in, port_clock_line_in);

    // Two flip-flops bring the asynchronous pins onto clk_link
    always_ff @(posedge clk_link or negedge nrst) begin
        if (!nrst) begin
            lnk_s1_q <= KPS_RST_PIN_LEVELS;
            lnk_s2_q <= KPS_RST_PIN_LEVELS;
        end else begin
            lnk_s1_q <= pin_raw;
            lnk_s2_q <= lnk_s1_q;
        end
    end

    // ------------------------------------------------------------------
    // Crossing to clk_sys
    // ------------------------------------------------------------------
    logic [7:0] sys_s1_q;
    logic [7:0] sys_s2_q;

    // Each line is an independent level, so bitwise two-flop crossing
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sys_s1_q <= KPS_RST_PIN_LEVELS;
            sys_s2_q <= KPS_RST_PIN_LEVELS;
        end else begin
            sys_s1_q <= lnk_s2_q;
            sys_s2_q <= sys_s1_q;
        end
    end

    // Input register view, same layout as the output register
    assign in_level = kps_sig_t'(sys_s2_q);

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------

    // Read data selected now, presented in the following cycle only
    assign rdata_d = !reg_rd ? KPS_RST_READ_DATA
                   : hit_out ? 8'(out_sig_q)
                   : hit_in  ? 8'(in_level)
                   : KPS_RST_READ_DATA;

    // Read data register; unmapped or idle cycles return zero
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= KPS_RST_READ_DATA;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

endmodule

// ### kps_pkg.sv
/*
 * Shared constants and types for the PS/2 port pin signal register bank.
 * Assumes a 16-bit register address space and four PS/2 channels.
 */
package kps_pkg;

    // ------------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------------
    localparam int unsigned KPS_CHANNELS  = 4;
    localparam int unsigned KPS_ADDR_W    = 16;
    localparam int unsigned KPS_DATA_W    = 8;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [15:0] KPS_OFS_OUTPUT_SIGNAL = 16'hfe86;
    localparam logic [15:0] KPS_OFS_INPUT_SIGNAL  = 16'hfe88;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] KPS_RST_OUTPUT_SIGNAL = 8'h47;
    localparam logic [7:0] KPS_RST_READ_DATA     = 8'h00;
    localparam logic [7:0] KPS_RST_PIN_LEVELS    = 8'hff;
    localparam logic [3:0] KPS_RST_DRIVE         = 4'h0;

    // ------------------------------------------------------------------
    // Field positions shared by both registers
    // ------------------------------------------------------------------
    localparam int unsigned KPS_POS_DAT1 = 0;
    localparam int unsigned KPS_POS_DAT2 = 1;
    localparam int unsigned KPS_POS_DAT3 = 2;
    localparam int unsigned KPS_POS_CLOCK_RELEASE_CH1 = 3;
    localparam int unsigned KPS_POS_CLOCK_RELEASE_CH2 = 4;
    localparam int unsigned KPS_POS_CLOCK_RELEASE_CH3 = 5;
    localparam int unsigned KPS_POS_DAT4 = 6;
    localparam int unsigned KPS_POS_CLOCK_RELEASE_CH4 = 7;

    // ------------------------------------------------------------------
    // Byte layout of the output and input signal registers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic clock_release_ch4;
        logic dat4;
        logic clock_release_ch3;
        logic clock_release_ch2;
        logic clock_release_ch1;
        logic dat3;
        logic dat2;
        logic dat1;
    } kps_sig_t;

    // Open-drain pin group for one kind of line, one bit per channel
    typedef struct packed {
        logic [3:0] o;
        logic [3:0] oe;
        logic [3:0] pu;
    } kps_pin_drv_t;

endpackage

// ### kps_pin_regs_asserts.sv
/* Port-level checker for the PS/2 pin signal register bank.
   Assumes bus strobes last one cycle and nrst is active low. */
module kps_pin_regs_asserts
    import kps_pkg::*;
(
    input wire logic         clk_sys,
    input wire logic         nrst,
    input wire logic [15:0]  reg_addr,
    input wire logic [7:0]   reg_wdata,
    input wire logic         reg_wr,
    input wire logic         reg_rd,
    input wire logic [7:0]   reg_rdata,
    input wire logic         shift_enable,
    input wire logic         weak_pullup_enable,
    input wire logic [3:0]   tx_active_entry,
    input wire logic [3:0]   engine_data_low,
    input wire logic [3:0]   channel_active,
    input wire logic         shift_reset,
    input wire kps_pin_drv_t port_data_line,
    input wire kps_pin_drv_t port_clock_line
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    // Engine enters transmit-active, then leaves the data line alone
    sequence s_tx_entry;
        shift_enable && tx_active_entry != 4'h0 ##1 engine_data_low == 4'h0;
    endsequence
    // Write of the output register followed at once by its read
    sequence s_wr_rd;
        reg_wr && reg_addr == KPS_OFS_OUTPUT_SIGNAL
            && !(shift_enable && tx_active_entry != 4'h0)
            ##1 reg_rd && reg_addr == KPS_OFS_OUTPUT_SIGNAL;
    endsequence

    a_idle_rdata: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not zero outside a read");
    a_unmapped_rd: assert property (reg_rd && reg_addr != 16'hfe86
        && reg_addr != 16'hfe88 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_wr_rd_back: assert property (s_wr_rd
        |=> reg_rdata == $past(reg_wdata, 2))
        else $error("output register read back wrong");
    a_tx_set_data: assert property (s_tx_entry
        |=> (port_data_line.oe & $past(tx_active_entry, 2)) == 4'h0)
        else $error("data line still low after transmit entry");
    a_clk_all_low: assert property (shift_reset
        |=> port_clock_line.oe == 4'hf)
        else $error("clock lines not pulled low");
    a_active_gate: assert property (!shift_enable
        |-> channel_active == 4'h0)
        else $error("channel active with engine off");
    a_active_reset: assert property (shift_enable
        |-> (channel_active == 4'h0) == shift_reset)
        else $error("shift reset disagrees with active set");
    a_pullup_on: assert property (
        port_data_line.pu == ({4{weak_pullup_enable}} & ~port_data_line.oe)
        && port_clock_line.pu
        == ({4{weak_pullup_enable}} & ~port_clock_line.oe))
        else $error("pull-up enable wrong");
    a_open_drain: assert property (port_data_line.o == 4'h0
        && port_clock_line.o == 4'h0)
        else $error("open-drain output driven high");
endmodule

bind kps_pin_regs kps_pin_regs_asserts i_kps_pin_regs_asserts (.*);

// ### kps_ps2_dev_model.sv
/* Four behavioural PS/2 peripherals on open-drain lines.
   Assumes pull-ups hold every released line high. */
module kps_ps2_dev_model
    import kps_pkg::*;
(
    input  wire kps_pin_drv_t data_drv,
    input  wire kps_pin_drv_t clock_drv,
    input  wire logic [3:0]   dev_data_low,
    input  wire logic [3:0]   dev_clock_low,
    output logic      [3:0]   data_level,
    output logic      [3:0]   clock_level
);
    timeunit 1ns;
    timeprecision 1ps;
    // Wired-AND: either party pulling low wins, else the pull-up
    assign data_level  = ~(data_drv.oe | dev_data_low);
    assign clock_level = ~(clock_drv.oe | dev_clock_low);
endmodule

// ### test_kbd_port_pin_signal_regs.sv
/* Random self-checking bench for the PS/2 pin signal registers.
   Assumes the device model resolves the lines for the design. */
module test_kbd_port_pin_signal_regs;
    import kps_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic         clk_sys, clk_link, nrst, reg_wr, reg_rd, shift_enable;
    logic         weak_pullup_enable, shift_reset;
    logic [15:0]  reg_addr;
    logic [7:0]   reg_wdata, reg_rdata, v;
    logic [3:0]   tx_active_entry, engine_data_low, engine_clock_low, c;
    logic [3:0]   channel_active, port_data_line_in, port_clock_line_in;
    logic [3:0]   dlow, clow;
    kps_pin_drv_t port_data_line, port_clock_line;
    int           fails, n_checks;

    kps_pin_regs i_kps_pin_regs (.*);
    kps_ps2_dev_model i_kps_ps2_dev_model (.data_drv(port_data_line),
        .clock_drv(port_clock_line), .dev_data_low(dlow),
        .dev_clock_low(clow), .data_level(port_data_line_in),
        .clock_level(port_clock_line_in));

    // Clocks: 8 ns core, 30 ns link
    always #4 clk_sys = ~clk_sys;
    always #15 clk_link = ~clk_link;

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    function automatic logic [3:0] db(logic [7:0] b);
        return {b[6], b[2:0]};
    endfunction
    function automatic logic [3:0] cb(logic [7:0] b);
        return {b[7], b[5:3]};
    endfunction
    function automatic logic [7:0] pk(logic [3:0] d, logic [3:0] k);
        return {k[3], d[3], k[2:0], d[2:0]};
    endfunction
    task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    // One bus cycle, sampled at the next rising edge
    task automatic bus(logic w, logic r, logic [15:0] a, logic [7:0] d);
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
    endtask
    task automatic rd(logic [15:0] a, logic [7:0] exp, string what);
        bus(1'b0, 1'b1, a, 8'h00);
        #1;
        chk(what, reg_rdata, exp);
        bus(1'b0, 1'b0, a, 8'h00);
    endtask
    task automatic results;
        $display("checks %0d, mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk_sys);
        fails++;
        results;
    end

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        {clk_sys, clk_link, nrst, reg_wr, reg_rd, shift_enable} = '0;
        {weak_pullup_enable, reg_addr, reg_wdata, dlow, clow} = '0;
        {tx_active_entry, engine_data_low, engine_clock_low} = '0;
        {fails, n_checks} = '0;
        void'($urandom(8902));
        repeat (5) @(posedge clk_sys);
        nrst <= 1'b1;
        rd(KPS_OFS_OUTPUT_SIGNAL, KPS_RST_OUTPUT_SIGNAL, "reset");
        chk("clk oe", {4'h0, port_clock_line.oe}, 8'h0f);
        $display("reset test done");
        for (int i = 0; i < 24; i++) begin
            v = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
            bus(1'b1, 1'b0, KPS_OFS_OUTPUT_SIGNAL, v);
            rd(KPS_OFS_OUTPUT_SIGNAL, v, "readback");
            chk("dat oe", {4'h0, port_data_line.oe}, {4'h0, ~db(v)});
            chk("clk oe", {4'h0, port_clock_line.oe}, {4'h0, ~cb(v)});
            chk("sreset", {7'h0, shift_reset}, {7'h0, cb(v) == 4'h0});
            dlow <= 4'($urandom);
            clow <= 4'($urandom);
            weak_pullup_enable <= 1'($urandom);
            repeat (14) @(posedge clk_sys);
            rd(KPS_OFS_INPUT_SIGNAL, pk(db(v) & ~dlow, cb(v) & ~clow),
                "levels");
            chk("pull", {port_data_line.pu, port_clock_line.pu},
                weak_pullup_enable ? {db(v), cb(v)} : 8'h00);
        end
        bus(1'b1, 1'b0, KPS_OFS_INPUT_SIGNAL, ~v);
        rd(KPS_OFS_OUTPUT_SIGNAL, v, "ro write");
        rd(16'hfe87, 8'h00, "unmapped");
        $display("direct drive test done");
        {dlow, clow} <= 8'h00;
        shift_enable <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            c = (i == 0) ? 4'h0 : 4'($urandom);
            bus(1'b1, 1'b0, KPS_OFS_OUTPUT_SIGNAL, pk(4'hf, c));
            engine_data_low <= 4'($urandom);
            engine_clock_low <= 4'($urandom);
            bus(1'b0, 1'b0, 16'h0000, 8'h00);
            #1;
            chk("active", {4'h0, channel_active}, {4'h0, c});
            chk("eng dat", {4'h0, port_data_line.oe},
                {4'h0, c & engine_data_low});
            chk("eng clk", {4'h0, port_clock_line.oe},
                {4'h0, ~c | engine_clock_low});
            // Request to send on one channel, then transmit-active entry
            bus(1'b1, 1'b0, KPS_OFS_OUTPUT_SIGNAL,
                pk(~(4'h1 << (i % 4)), 4'hf));
            tx_active_entry <= 4'h1 << (i % 4);
            engine_data_low <= 4'h0;
            bus(1'b0, 1'b0, 16'h0000, 8'h00);
            tx_active_entry <= 4'h0;
            rd(KPS_OFS_OUTPUT_SIGNAL, 8'hff, "tx set");
            // Abandoned request: pull the data low again, then restore write-data with clocks still released
            bus(1'b1, 1'b0, KPS_OFS_OUTPUT_SIGNAL,
                pk(~(4'h1 << (i % 4)), 4'hf));
            bus(1'b1, 1'b0, KPS_OFS_OUTPUT_SIGNAL, pk(4'hf, 4'hf));
            rd(KPS_OFS_OUTPUT_SIGNAL, 8'hff, "abandon");
        end
        $display("engine test done");
        results;
    end
endmodule
